// file: rtl/sat_attenuator.sv
// Shift, latch and tap-decode logic of a three-channel stepped attenuator.
// Assumes the host drives the shift clock only while the frame strobe is low.
`timescale 1ns/10ps
module sat_attenuator #(
    parameter int NUM_CH = sat_pkg::NUM_CH
) (
    input wire logic core_clk, // Core clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic shift_clk, // Shift clock from the host.
    input wire logic data_in, // Serial frame data.
    input wire logic load_n, // Frame strobe, low while shifting.
    output logic data_out, // Chain output toward the next device.
    output logic [NUM_CH*7-1:0] tap_sel, // Selected tap index per channel.
    output logic [NUM_CH-1:0] mute, // Mute state per channel.
    output logic frame_done // One-cycle pulse after each decoded frame.
);

    // Link domain: these registers run on the host's shift clock. The host
    // changes the data pin and the strobe in step with that clock, so both
    // are read here directly and need no synchroniser in this domain.
    logic [sat_pkg::FRAME_BITS-1:0] shreg_q;
    logic [sat_pkg::FRAME_BITS-1:0] shreg_d;
    logic chain_q;
    logic chain_d;

    always_comb begin
        shreg_d = shreg_q;
        chain_d = chain_q;
        if (!load_n) begin
            shreg_d = {shreg_q[sat_pkg::FRAME_BITS-2:0], data_in};
            chain_d = shreg_q[sat_pkg::FRAME_BITS-1];
        end
    end

    always_ff @(posedge shift_clk or posedge rst) begin
        if (rst) begin
            shreg_q <= sat_pkg::SHREG_RESET;
            chain_q <= sat_pkg::CHAIN_RESET;
        end else begin
            shreg_q <= shreg_d;
            chain_q <= chain_d;
        end
    end

    // Core domain: strobe synchroniser. Its flops rest at the strobe's idle
    // level, so the release of reset never looks like a rising strobe.
    logic strb1_q;
    logic strb1_d;
    logic strb2_q;
    logic strb2_d;
    logic strb3_q;
    logic strb3_d;

    always_comb begin
        strb1_d = load_n;
        strb2_d = strb1_q;
        strb3_d = strb2_q;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strb1_q <= sat_pkg::STROBE_IDLE;
            strb2_q <= sat_pkg::STROBE_IDLE;
            strb3_q <= sat_pkg::STROBE_IDLE;
        end else begin
            strb1_q <= strb1_d;
            strb2_q <= strb2_d;
            strb3_q <= strb3_d;
        end
    end

    logic latch_now;
    assign latch_now = strb2_q & ~strb3_q;

    // Chain output resynchronised to the core clock. A device further down
    // the chain sees each bit up to two core cycles late, which must stay
    // well inside half a shift clock period.
    logic chs1_q;
    logic chs1_d;
    logic chs2_q;
    logic chs2_d;

    always_comb begin
        chs1_d = chain_q;
        chs2_d = chs1_q;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chs1_q <= sat_pkg::CHAIN_RESET;
            chs2_q <= sat_pkg::CHAIN_RESET;
        end else begin
            chs1_q <= chs1_d;
            chs2_q <= chs2_d;
        end
    end

    // Holding latch. The shift register is taken a few core cycles after the
    // strobe rose; it cannot move then, because shifting needs the strobe low.
    // The word crosses without a synchroniser for that reason. A host that
    // lowers the strobe again within three core cycles would spoil the capture,
    // so frames must be spaced.
    logic [sat_pkg::FRAME_BITS-1:0] frame_q;
    logic [sat_pkg::FRAME_BITS-1:0] frame_d;

    always_comb begin
        frame_d = frame_q;
        if (latch_now) begin
            frame_d = shreg_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_q <= sat_pkg::FRAME_RESET;
        end else begin
            frame_q <= frame_d;
        end
    end

    // Marks the cycle in which the held frame is fresh and may be decoded.
    logic new_q;
    logic new_d;

    always_comb begin
        new_d = latch_now;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            new_q <= sat_pkg::FLAG_RESET;
        end else begin
            new_q <= new_d;
        end
    end

    logic [sat_pkg::BYTE_BITS-1:0] addr;
    logic [sat_pkg::BYTE_BITS-1:0] code;
    assign addr = frame_q[sat_pkg::FRAME_BITS-1:sat_pkg::BYTE_BITS];
    assign code = frame_q[sat_pkg::BYTE_BITS-1:0];

    // The code falls into one of three regions. Fine and two dB codes both
    // name their tap directly, so the tap index is the code itself; only
    // the mute region folds many codes onto the single mute tap.
    typedef enum logic [2:0] {
        CLS_FINE = 3'b001,
        CLS_COARSE = 3'b010,
        CLS_MUTE = 3'b100
    } sat_code_class_t;
    sat_code_class_t code_class;

    always_comb begin
        code_class = CLS_FINE;
        if (code >= sat_pkg::CODE_MUTE_FIRST) begin
            code_class = CLS_MUTE;
        end else if (code >= sat_pkg::CODE_COARSE_FIRST) begin
            code_class = CLS_COARSE;
        end
    end

    logic [sat_pkg::TAP_BITS-1:0] tap_new;
    logic mute_new;

    always_comb begin
        tap_new = sat_pkg::TAP_MUTE;
        mute_new = 1'b1;
        unique case (code_class)
            CLS_FINE: begin
                tap_new = code[sat_pkg::TAP_BITS-1:0];
                mute_new = 1'b0;
            end
            CLS_COARSE: begin
                tap_new = code[sat_pkg::TAP_BITS-1:0];
                mute_new = 1'b0;
            end
            CLS_MUTE: begin
                tap_new = sat_pkg::TAP_MUTE;
                mute_new = 1'b1;
            end
        endcase
    end

    // Channel addresses come from the package. Beyond the three listed
    // channels the channel index itself serves as the address.
    function automatic logic [7:0] chan_addr(input int idx);
        logic [7:0] a;
        a = 8'(idx);
        if (idx == 0) begin
            a = sat_pkg::ADDR_CH0;
        end else if (idx == 1) begin
            a = sat_pkg::ADDR_CH1;
        end else if (idx == 2) begin
            a = sat_pkg::ADDR_CH2;
        end
        return a;
    endfunction

    // One tap register and one mute flag per channel. A frame with an
    // unknown address changes no channel, yet still ends in a done pulse.
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [sat_pkg::TAP_BITS-1:0] tap_q;
            logic [sat_pkg::TAP_BITS-1:0] tap_d;
            logic mute_q;
            logic mute_d;
            logic hit;

            assign hit = new_q && (addr == chan_addr(ch));

            always_comb begin
                tap_d = tap_q;
                mute_d = mute_q;
                if (hit) begin
                    tap_d = tap_new;
                    mute_d = mute_new;
                end
            end

            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    tap_q <= sat_pkg::TAP_MUTE;
                    mute_q <= sat_pkg::MUTE_RESET;
                end else begin
                    tap_q <= tap_d;
                    mute_q <= mute_d;
                end
            end

            assign tap_sel[ch*sat_pkg::TAP_BITS +: sat_pkg::TAP_BITS] = tap_q;
            assign mute[ch] = mute_q;
        end
    endgenerate

    // Done pulse, raised in the same cycle in which the new tap shows, so a
    // watcher can sample the outputs while the pulse stands.
    logic done_q;
    logic done_d;

    always_comb begin
        done_d = new_q;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_q <= sat_pkg::FLAG_RESET;
        end else begin
            done_q <= done_d;
        end
    end

    assign data_out = chs2_q;
    assign frame_done = done_q;

endmodule

// file: rtl/sat_pkg.sv
// Constants shared by the serial attenuator control logic.
// Assumes one core clock and one shift clock supplied by the host.
package sat_pkg;
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int NUM_CH = 3;
    localparam int TAP_BITS = 7;
    // Attenuation code boundaries.
    localparam logic [7:0] CODE_FINE_LAST = 8'h3F;
    localparam logic [7:0] CODE_COARSE_FIRST = 8'h40;
    localparam logic [7:0] CODE_COARSE_LAST = 8'h4E;
    localparam logic [7:0] CODE_MUTE_FIRST = 8'h4F;
    // Tap index used for the muted state.
    localparam logic [6:0] TAP_MUTE = 7'h4F;
    localparam logic [7:0] CODE_RESET = 8'hFF;
    // Channel address values are not published; neutral defaults.
    localparam logic [7:0] ADDR_CH0 = 8'h00;
    localparam logic [7:0] ADDR_CH1 = 8'h01;
    localparam logic [7:0] ADDR_CH2 = 8'h02;
    // Values after reset.
    localparam logic [15:0] SHREG_RESET = 16'h0000;
    localparam logic [15:0] FRAME_RESET = 16'h0000;
    localparam logic CHAIN_RESET = 1'b0;
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic MUTE_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
endpackage

// file: verif/sat_attenuator_sva.sv
// Port checker for the attenuator.
// Assumes a bind to sat_attenuator.
`timescale 1ns/10ps
module sat_attenuator_sva #(parameter int NUM_CH = 3) (
    input wire logic core_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic shift_clk, // Link.
    input wire logic data_in, // Data.
    input wire logic load_n, // Strobe.
    input wire logic data_out, // Chain.
    input wire logic [NUM_CH*7-1:0] tap_sel, // Taps.
    input wire logic [NUM_CH-1:0] mute, // Mutes.
    input wire logic frame_done // Done.
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    AST_RST_MUTE: assert property ($fell(rst) |-> &mute) else $error("mute");
    AST_MUTE_TAP: assert property (mute[0] == (tap_sel[6:0] == 7'h4F)) else $error("tap");
    AST_RANGE: assert property (tap_sel[13:7] <= 7'h4F) else $error("range");
    AST_HOLD: assert property (!frame_done |-> $stable(tap_sel)) else $error("hold");
    AST_PULSE: assert property (frame_done |=> !frame_done) else $error("pulse");
    AST_LATCH: assert property ($rose(load_n) |-> ##[3:8] frame_done) else $error("latch");
    AST_QUIET: assert property (!load_n |-> !frame_done) else $error("quiet");
    AST_ONE_CH: assert property (frame_done |-> $countones({tap_sel[6:0] == $past(tap_sel[6:0]),
        tap_sel[13:7] == $past(tap_sel[13:7]), tap_sel[20:14] == $past(tap_sel[20:14])}) >= 2) else $error("one");
    cover property (frame_done && mute[1]);
    cover property (frame_done && !mute[1]);
    cover property ($rose(load_n));
endmodule
bind sat_attenuator sat_attenuator_sva #(.NUM_CH(NUM_CH)) chk (.core_clk, .rst, .shift_clk, .data_in, .load_n,
    .data_out, .tap_sel, .mute, .frame_done);

// file: verif/sat_host.sv
// Host model; the link clock stands still between frames, except in the stray task.
// Assumes the bench spaces the frames.
`timescale 1ns/10ps
module sat_host (
    output logic shift_clk = 1'b0, // Link.
    output logic data_in = 1'b0, // Data.
    output logic load_n = 1'b1, // Strobe.
    input wire logic data_out, // Chain.
    output logic [31:0] seen = '0 // Chain bits.
);
    task automatic send(input logic [31:0] f, input int nb);
        load_n = 1'b0;
        #163;
        for (int i = nb - 1; i >= 0; i--) begin
            data_in = f[i];
            #40 shift_clk = 1'b1;
            #40 seen = {seen[30:0], data_out};
            shift_clk = 1'b0;
        end
        #40 load_n = 1'b1;
    endtask
    task automatic stray(input logic [31:0] f, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            data_in = f[i];
            #40 shift_clk = 1'b1;
            #40 shift_clk = 1'b0;
        end
    endtask
endmodule

// file: verif/sat_attenuator_test.sv
// Bench for the attenuator.
// Assumes sat_host drives the link.
`timescale 1ns/10ps
module sat_attenuator_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic shift_clk, data_in, load_n, data_out, frame_done;
    logic [20:0] tap_sel;
    logic [20:0] et = {3{7'h4F}};
    logic [2:0] mute;
    logic [2:0] em = 3'h7;
    logic [31:0] seen;
    logic [7:0] codes [6] = '{8'h3E, 8'h3F, 8'h40, 8'h4E, 8'h4F, 8'hFF};
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 core_clk = ~core_clk;
    sat_host host (.shift_clk, .data_in, .load_n, .data_out, .seen);
    sat_attenuator dut (.core_clk, .rst, .shift_clk, .data_in, .load_n, .data_out, .tap_sel, .mute, .frame_done);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic frame(input logic [31:0] f, input int nb);
        host.send(f, nb);
        for (int i = 0; i < 20 && frame_done !== 1'b1; i++)
            @(negedge core_clk);
        chk(frame_done, 1'b1);
        if (f[15:8] < 8'h03) begin
            et[f[9:8]*7 +: 7] = (f[7:0] > 8'h4E) ? 7'h4F : f[6:0];
            em[f[9:8]] = f[7:0] > 8'h4E;
        end
        chk(tap_sel, et);
        chk(mute, em);
        repeat (12) @(negedge core_clk);
    endtask
    task automatic check_idle();
        et = {3{7'h4F}};
        em = 3'h7;
        chk(mute, em);
        chk(tap_sel, et);
        chk(frame_done, 1'b0);
        chk(data_out, 1'b0);
    endtask
    task automatic test_power_up();
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check_idle();
    endtask
    task automatic test_codes();
        foreach (codes[i])
            frame({8'h01, codes[i]}, 16);
    endtask
    task automatic test_address();
        frame(16'h0500, 16);
        frame(16'h0241, 16);
    endtask
    task automatic test_stray_clock();
        host.stray(16'h0230, 16);
        frame(16'h0241, 0);
    endtask
    task automatic test_chain();
        frame({16'h0210, 16'h0020}, 32);
        chk(seen[31:16], 16'h0241);
        chk(seen[15:0], 16'h0210);
    endtask
    task automatic test_mid_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check_idle();
        frame(16'h0120, 16);
    endtask
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        test_power_up();
        test_codes();
        test_address();
        test_stray_clock();
        test_chain();
        test_mid_reset();
        give_verdict();
    end
endmodule
